// *** rtl/trc_touch_conv.sv ***
`timescale 1ns/10ps
// How it works
// - low byte write only fills holding buffer
// - high write loads byte, buffer to low
// - high read returns high, latches low
// - low read returns latched low byte only
// - control 02h enables mode, reference overflow source
// - clock control 30h selects div4, starts run
// - interrupt flag bit 5, set by device
// - eight touch lines, four on small variant
// - touch lines contiguous from first, rest gpio
// - build option gives oscillator pin or gpio
// - build options fixed, invisible to software
// - selected overflow sets flag; either clears run, stops both
// - bit1 mode enable, bit0 overflow source
// - counters unreachable by software while running
module trc_touch_conv import trc_pkg::*; #(
  parameter int MAX_LINES   = 8,
  parameter int TOUCH_LINES = 8,
  parameter bit RF_ENABLE   = 1'b1
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // port c pins and touch switches
  input  wire logic [7:0]  pc_in,
  output logic      [7:0]  pc_out,
  output logic      [7:0]  pc_oe_n,
  output logic      [7:0]  touch_switch_lines,
  // port d pin, oscillator input
  input  wire logic        pd_in,
  output logic             pd_out,
  output logic             pd_oe_n
);
  // build-time line count, clipped to variant
  localparam int LINES = (TOUCH_LINES < MAX_LINES) ? TOUCH_LINES : MAX_LINES;
  ////////////////////////////////////////////////////////////////////////////
  // state
  trc_bus_e    bus_q;            // handshake state
  logic        wait_q;           // waitrequest flop
  logic [31:0] rdata_q;          // read data flop
  logic        irq_q;            // interrupt flop
  logic        mode_q;           // converter mode enable
  logic        ovsel_q;          // overflow source select
  logic        div4_q;           // reference clock divide by four
  logic        run_q;            // converter run
  logic        flag_q;           // converter interrupt flag
  logic        mask_q;           // interrupt mask
  logic [1:0]  div_q;            // prescaler
  logic [7:0]  pc_dout_q;        // port c data out
  logic [7:0]  pc_dir_q;         // port c direction, 1 output
  logic [7:0]  sw_sel_q;         // closed touch switches
  logic        pd_dout_q;        // port d data out
  logic        pd_dir_q;         // port d direction
  logic [7:0]  pc_out_q;         // pin flops
  logic [7:0]  pc_oe_n_q;
  logic [7:0]  tsw_q;
  logic        pd_out_q;
  logic        pd_oe_n_q;
  ////////////////////////////////////////////////////////////////////////////
  // pins in through synchronisers
  logic [7:0] pc_sync;           // port c levels
  logic       pd_sync;           // port d level
  logic       osc_rise;          // oscillator rising edge
  trc_sync #(.W(8)) u_pc_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .raw     (pc_in),
    .sync    (pc_sync),
    .rise    ()
  );
  trc_sync #(.W(1)) u_pd_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .raw     (pd_in),
    .sync    (pd_sync),
    .rise    (osc_rise)
  );
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req      = avs_read | avs_write;                 // request present
  wire acc      = req && (bus_q == BUS_ACK);            // access completes
  wire wr_acc   = acc && avs_write && avs_byteenable[0];
  wire rd_acc   = acc && avs_read;
  wire [7:0] wb = avs_writedata[7:0];                   // written byte
  wire cnt_ok   = !run_q;
  wire wr_ctrl  = wr_acc && (avs_address == OFF_CTRL);
  wire wr_clk   = wr_acc && (avs_address == OFF_CLKCTRL);
  wire wr_stat  = wr_acc && (avs_address == OFF_IRQ_STAT);
  wire wr_mask  = wr_acc && (avs_address == OFF_IRQ_MASK);
  wire wr_pco   = wr_acc && (avs_address == OFF_PC_OUT);
  wire wr_pcd   = wr_acc && (avs_address == OFF_PC_DIR);
  wire wr_pd    = wr_acc && (avs_address == OFF_PD);
  wire wr_sw    = wr_acc && (avs_address == OFF_SW_SEL);
  wire wr_ref_l = wr_acc && cnt_ok && (avs_address == OFF_REF_LO);
  wire wr_ref_h = wr_acc && cnt_ok && (avs_address == OFF_REF_HI);
  wire wr_osc_l = wr_acc && cnt_ok && (avs_address == OFF_OSC_LO);
  wire wr_osc_h = wr_acc && cnt_ok && (avs_address == OFF_OSC_HI);
  wire rd_ref_h = rd_acc && cnt_ok && (avs_address == OFF_REF_HI);
  wire rd_osc_h = rd_acc && cnt_ok && (avs_address == OFF_OSC_HI);
  ////////////////////////////////////////////////////////////////////////////
  // counters
  logic [15:0] ref_cnt;          // reference timer
  logic [15:0] osc_cnt;          // oscillator counter
  logic [7:0]  ref_lat;          // latched low bytes
  logic [7:0]  osc_lat;
  logic        ref_ovf;          // overflow pulses
  logic        osc_ovf;
  wire div_tick = (div_q == DIV4_LAST);                 // one pulse in four
  wire counting = mode_q && run_q;
  wire ref_inc  = counting && (!div4_q || div_tick);
  wire osc_inc  = counting && RF_ENABLE && osc_rise;
  wire any_ovf  = ref_ovf || osc_ovf;
  wire sel_ovf  = ovsel_q ? osc_ovf : ref_ovf;

  trc_cnt16 u_ref (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .inc      (ref_inc),
    .wr_lo    (wr_ref_l),
    .wr_hi    (wr_ref_h),
    .rd_hi    (rd_ref_h),
    .wdata    (wb),
    .count_q  (ref_cnt),
    .lo_buf_q (),
    .lo_lat_q (ref_lat),
    .ovf      (ref_ovf)
  );

  trc_cnt16 u_osc (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .inc      (osc_inc),
    .wr_lo    (wr_osc_l),
    .wr_hi    (wr_osc_h),
    .rd_hi    (rd_osc_h),
    .wdata    (wb),
    .count_q  (osc_cnt),
    .lo_buf_q (),
    .lo_lat_q (osc_lat),
    .ovf      (osc_ovf)
  );
  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped and blocked reads give zero
  function automatic logic [7:0] rd_byte(input logic [5:0] a);
    logic [7:0] v;
    v = BYTE_RST;
    if (a == OFF_CTRL) v = {6'h00, mode_q, ovsel_q};
    else if (a == OFF_CLKCTRL) v = {2'h0, div4_q, run_q, 4'h0};
    else if (a == OFF_REF_LO && cnt_ok) v = ref_lat;
    else if (a == OFF_REF_HI && cnt_ok) v = ref_cnt[15:8];
    else if (a == OFF_OSC_LO && cnt_ok) v = osc_lat;
    else if (a == OFF_OSC_HI && cnt_ok) v = osc_cnt[15:8];
    else if (a == OFF_IRQ_STAT) v = {2'h0, flag_q, 5'h00};
    else if (a == OFF_IRQ_MASK) v = {2'h0, mask_q, 5'h00};
    else if (a == OFF_PC_OUT) v = pc_dout_q;
    else if (a == OFF_PC_DIR) v = pc_dir_q;
    else if (a == OFF_PC_IN) v = pc_sync;
    else if (a == OFF_PD) v = {5'h00, pd_sync, pd_dir_q, pd_dout_q};
    else if (a == OFF_SW_SEL) v = sw_sel_q;
    return v;
  endfunction

  wire [7:0] rd_mux = rd_byte(avs_address);
  ////////////////////////////////////////////////////////////////////////////
  // handshake: one wait cycle, then waitrequest low for one
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bus_q  <= BUS_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (req) begin
            bus_q  <= BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_q  <= BUS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_q  <= BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // read data captured as waitrequest drops
  always_ff @(posedge ref_clk) begin
    if (!nrst) rdata_q <= 32'h0000_0000;
    else if (req && bus_q == BUS_IDLE) rdata_q <= {24'h000000, rd_mux};
  end
  ////////////////////////////////////////////////////////////////////////////
  // converter control
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q  <= BIT_RST;
      ovsel_q <= BIT_RST;
    end else if (wr_ctrl) begin
      mode_q  <= wb[CTRL_MODE_BIT];
      ovsel_q <= wb[CTRL_OVSEL_BIT];
    end
  end

  // clock select and run, overflow clears run
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div4_q <= BIT_RST;
      run_q  <= BIT_RST;
    end else begin
      if (wr_clk) div4_q <= wb[CLK_DIV4_BIT];
      if (any_ovf) run_q <= 1'b0;
      else if (wr_clk) run_q <= wb[CLK_RUN_BIT];
    end
  end

  // free-running prescaler
  always_ff @(posedge ref_clk) begin
    if (!nrst) div_q <= 2'h0;
    else       div_q <= div_q + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // sticky flag, write one clears, set wins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flag_q <= BIT_RST;
      mask_q <= BIT_RST;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= sel_ovf || (flag_q && !(wr_stat && wb[IRQ_FLAG_BIT]));
      if (wr_mask) mask_q <= wb[IRQ_FLAG_BIT];
      irq_q <= flag_q && mask_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // port registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pc_dout_q <= BYTE_RST;
      pc_dir_q  <= BYTE_RST;
      sw_sel_q  <= BYTE_RST;
      pd_dout_q <= BIT_RST;
      pd_dir_q  <= BIT_RST;
    end else begin
      if (wr_pco) pc_dout_q <= wb;
      if (wr_pcd) pc_dir_q  <= wb;
      if (wr_sw)  sw_sel_q  <= wb;
      if (wr_pd) begin
        pd_dout_q <= wb[PD_OUT_BIT];
        pd_dir_q  <= wb[PD_DIR_BIT];
      end
    end
  end

  // per line: touch line released, others gpio
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_line
      wire line_en = (gi < LINES);
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          pc_out_q[gi]  <= 1'b0;
          pc_oe_n_q[gi] <= 1'b1;
          tsw_q[gi]     <= 1'b0;
        end else begin
          pc_out_q[gi]  <= !line_en && pc_dout_q[gi];
          pc_oe_n_q[gi] <= line_en || !pc_dir_q[gi];
          tsw_q[gi]     <= line_en && mode_q && sw_sel_q[gi];
        end
      end
    end
  endgenerate

  // port d: oscillator input when option set
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pd_out_q  <= 1'b0;
      pd_oe_n_q <= 1'b1;
    end else begin
      pd_out_q  <= !RF_ENABLE && pd_dout_q;
      pd_oe_n_q <= RF_ENABLE || !pd_dir_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata       = rdata_q;
  assign avs_waitrequest    = wait_q;
  assign irq                = irq_q;
  assign pc_out             = pc_out_q;
  assign pc_oe_n            = pc_oe_n_q;
  assign touch_switch_lines = tsw_q;
  assign pd_out             = pd_out_q;
  assign pd_oe_n            = pd_oe_n_q;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  ctrl_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_ctrl && wb == 8'h02 |=> mode_q && !ovsel_q)
    else $error("control write did not enable mode");
  clk_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_clk && wb == 8'h30 && !any_ovf |=> div4_q && run_q)
    else $error("clock control write did not start");
  flag_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sel_ovf |=> flag_q ##1 irq_q == $past(mask_q))
    else $error("overflow did not raise flag");
  ovf_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    any_ovf |=> !run_q && !ref_inc && !osc_inc)
    else $error("overflow did not stop counters");
  blocked_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    run_q && req && bus_q == BUS_IDLE && avs_address >= OFF_REF_LO && avs_address <= OFF_OSC_HI
    |=> rdata_q == 32'h0)
    else $error("counter read while running");
  lines_free_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ##1 pc_oe_n_q[0] || LINES == 0)
    else $error("touch line driven");
  osc_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    osc_inc && !osc_ovf |=> osc_cnt == $past(osc_cnt) + 16'h0001)
    else $error("oscillator edge not counted");
  ack_once_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !wait_q |=> wait_q)
    else $error("waitrequest low twice");
  meas_done_c: cover property (@(posedge ref_clk) disable iff (!nrst) run_q ##1 !run_q);
  osc_ovf_c:   cover property (@(posedge ref_clk) disable iff (!nrst) osc_ovf && ovsel_q);
  irq_c:       cover property (@(posedge ref_clk) disable iff (!nrst) irq_q);
endmodule

// *** rtl/trc_pkg.sv ***
package trc_pkg;
  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_CTRL     = 6'h00;
  localparam logic [5:0] OFF_CLKCTRL  = 6'h04;
  localparam logic [5:0] OFF_REF_LO   = 6'h08;
  localparam logic [5:0] OFF_REF_HI   = 6'h0c;
  localparam logic [5:0] OFF_OSC_LO   = 6'h10;
  localparam logic [5:0] OFF_OSC_HI   = 6'h14;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h18;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h1c;
  localparam logic [5:0] OFF_PC_OUT   = 6'h20;
  localparam logic [5:0] OFF_PC_DIR   = 6'h24;
  localparam logic [5:0] OFF_PC_IN    = 6'h28;
  localparam logic [5:0] OFF_PD       = 6'h2c;
  localparam logic [5:0] OFF_SW_SEL   = 6'h30;
  // field positions
  localparam int CTRL_OVSEL_BIT = 0;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CLK_RUN_BIT    = 4;
  localparam int CLK_DIV4_BIT   = 5;
  localparam int IRQ_FLAG_BIT   = 5;
  localparam int PD_OUT_BIT     = 0;
  localparam int PD_DIR_BIT     = 1;
  localparam int PD_IN_BIT      = 2;
  // values after reset
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic        BIT_RST   = 1'b0;
  // divide-by-four tick position
  localparam logic [1:0]  DIV4_LAST = 2'h3;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } trc_bus_e;
endpackage

// *** rtl/trc_sync.sv ***
`timescale 1ns/10ps
module trc_sync import trc_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // raw pin level
  input  wire logic [W-1:0] raw,
  // synchronised level and rising edge
  output logic      [W-1:0] sync,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta_q;  // first stage, read by second only
  logic [W-1:0] s2_q;    // settled level
  logic [W-1:0] s3_q;    // delayed copy for edge

  // two-flop synchroniser plus edge stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_q <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
    end else begin
      meta_q <= raw;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  assign sync = s2_q;
  assign rise = s2_q & ~s3_q;
endmodule

// *** rtl/trc_cnt16.sv ***
`timescale 1ns/10ps
module trc_cnt16 import trc_pkg::*; (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // count enable
  input  wire logic        inc,
  // byte accesses
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic        rd_hi,
  input  wire logic [7:0]  wdata,
  // state
  output logic      [15:0] count_q,
  output logic      [7:0]  lo_buf_q,
  output logic      [7:0]  lo_lat_q,
  output logic             ovf
);
  logic [15:0] count_d;  // next count

  // overflow when an increment meets the top
  assign ovf = inc && (count_q == COUNT_TOP);
  // high write loads pair, else count
  assign count_d = wr_hi ? {wdata, lo_buf_q} :
                   inc   ? count_q + 16'h0001 : count_q;

  // live count
  always_ff @(posedge ref_clk) begin
    if (!nrst) count_q <= COUNT_RST;
    else       count_q <= count_d;
  end

  // low write goes to holding buffer only
  always_ff @(posedge ref_clk) begin
    if (!nrst)      lo_buf_q <= BYTE_RST;
    else if (wr_lo) lo_buf_q <= wdata;
  end

  // high read latches the low byte
  always_ff @(posedge ref_clk) begin
    if (!nrst)      lo_lat_q <= BYTE_RST;
    else if (rd_hi) lo_lat_q <= count_q[7:0];
  end

  lo_write_held_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_lo && !wr_hi && !inc |=> count_q == $past(count_q) && lo_buf_q == $past(wdata))
    else $error("low write reached live count");
  hi_write_pair_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_hi |=> count_q == {$past(wdata), $past(lo_buf_q)})
    else $error("high write did not load pair");
  hi_read_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_hi |=> lo_lat_q == $past(count_q[7:0]))
    else $error("high read did not latch low byte");
  lo_lat_stable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !rd_hi |=> $stable(lo_lat_q))
    else $error("low latch moved without high read");
endmodule

// *** sim/trc_osc_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// rc oscillator on a touch pad, drives the oscillator pin
module trc_osc_model (
  // control
  input  wire logic en,
  input  wire logic [31:0] half_ns,
  // pad output
  output logic      osc
);
  // free running square wave; held low while powered down
  initial begin
    osc = 1'b0;
    forever begin
      #(half_ns);
      osc = en ? ~osc : 1'b0;
    end
  end
endmodule

// *** sim/test_touch_rc_oscillation_counter.sv ***
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
////////////////////////////////////////////////////////////////////////
module test_touch_rc_oscillation_counter
  import trc_pkg::*;
;
  logic        ref_clk;        // system clock
  logic        nrst;           // sync reset
  logic [5:0]  avs_address;    // bus address
  logic        avs_read;       // read request
  logic        avs_write;      // write request
  logic [31:0] avs_writedata;  // write data
  logic [3:0]  avs_byteenable; // byte lanes
  logic [31:0] avs_readdata;   // read data
  logic        avs_waitrequest; // wait
  logic        irq;            // interrupt
  logic [7:0]  pc_in;          // port c pins
  logic [7:0]  pc_out;         // port c drive
  logic [7:0]  pc_oe_n;        // port c enable
  logic [7:0]  touch_switch_lines; // analog switches
  logic        osc;            // oscillator pin
  logic        pd_out;         // port d drive
  logic        pd_oe_n;        // port d enable
  logic        osc_en;         // oscillator power
  logic [7:0]  rd;             // last read byte
  logic [7:0]  rnd;            // random byte
  int          error_cnt;      // mismatches
  int          cmp_count;      // comparisons
  int          seed;           // random seed
  int          v;              // counter value
  int          m_buf[2];       // model holding buffers
  int          m_lat[2];       // model low latches
  int          m_cnt[2];       // model live counts
  bit          m_run;          // model run bit
  time         t0;             // run start
  ////////////////////////////////////////////////////////////////////////
  trc_touch_conv #(.MAX_LINES(8), .TOUCH_LINES(3), .RF_ENABLE(1'b1)) trc_touch_conv_inst (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n),
    .touch_switch_lines(touch_switch_lines), .pd_in(osc), .pd_out(pd_out), .pd_oe_n(pd_oe_n)
  );
  trc_osc_model trc_osc_model_inst (.en(osc_en), .half_ns(200), .osc(osc));
  ////////////////////////////////////////////////////////////////////////
  // clock generation
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    // only the watchdog ends a stalled wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // register write with model update; counter writes ignored while running
  task wr(input logic [5:0] a, input logic [7:0] d);
    int i;
    bus(1'b1, a, d, 4'h1);
    i = (a >= OFF_OSC_LO);
    if (!m_run && a >= OFF_REF_LO && a <= OFF_OSC_HI) begin
      if (a[2]) m_cnt[i] = d * 256 + m_buf[i];
      else m_buf[i] = d;
    end
    if (a == OFF_CLKCTRL) m_run = d[CLK_RUN_BIT];
  endtask
  // register read against an expected byte
  task rdc(input logic [5:0] a, input int exp);
    bus(1'b0, a, 8'h00, 4'h1);
    `CHK(rd, exp);
  endtask
  // counter read, high byte first so the low byte is latched
  task cnt_rd(input int i, output int val);
    int hi;
    bus(1'b0, i ? OFF_OSC_HI : OFF_REF_HI, 8'h00, 4'h1);
    hi = rd;
    m_lat[i] = m_cnt[i] % 256;
    bus(1'b0, i ? OFF_OSC_LO : OFF_REF_LO, 8'h00, 4'h1);
    val = hi * 256 + rd;
  endtask
  // run with oscillator nearly full; flag follows source choice
  task run_case(input logic [7:0] ctrl, input logic [7:0] clk, input int exp_stat);
    wr(OFF_CTRL, ctrl);
    wr(OFF_IRQ_STAT, 8'h20);
    wr(OFF_REF_LO, 8'h00);
    wr(OFF_REF_HI, 8'h00);
    wr(OFF_OSC_LO, 8'hfd);
    wr(OFF_OSC_HI, 8'hff);
    wr(OFF_CLKCTRL, clk);
    repeat (150) @(posedge ref_clk);
    m_run = 1'b0;
    rdc(OFF_CLKCTRL, clk & 8'h20);
    rdc(OFF_IRQ_STAT, exp_stat);
    // run lasts 21 to 30 cycles: full rate counts all, div4 a quarter
    cnt_rd(0, v);
    `CHK(clk[CLK_DIV4_BIT] ? v <= 10 : v >= 18, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    #(40 * 8000);
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    seed = 62153;
    m_buf = '{0, 0};
    m_lat = '{0, 0};
    m_cnt = '{0, 0};
    m_run = 1'b0;
    nrst = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    pc_in = 8'h00;
    osc_en = 1'b1;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    // reset values and unmapped place
    rdc(OFF_CTRL, 0);
    rdc(OFF_CLKCTRL, 0);
    rdc(OFF_IRQ_MASK, 0);
    rdc(6'h3c, 0);
    `CHK({pd_oe_n, pd_out}, 2'b10);
    // buffered byte access
    rnd = $random(seed);
    wr(OFF_REF_LO, rnd);
    cnt_rd(0, v);
    `CHK(v, m_cnt[0]);
    wr(OFF_REF_HI, 8'hfe);
    cnt_rd(0, v);
    `CHK(v, m_cnt[0]);
    wr(OFF_REF_LO, 8'hc0);
    wr(OFF_REF_HI, 8'hff);
    rdc(OFF_REF_LO, m_lat[0]);
    // reference overflow run, mask off
    wr(OFF_OSC_LO, 8'h00);
    wr(OFF_OSC_HI, 8'h00);
    wr(OFF_CTRL, 8'h02);
    bus(1'b1, OFF_CTRL, 8'h00, 4'h0);
    rdc(OFF_CTRL, 8'h02);
    wr(OFF_IRQ_STAT, 8'h20);
    wr(OFF_CLKCTRL, 8'h30);
    t0 = $time;
    rdc(OFF_REF_HI, 0);
    wr(OFF_OSC_HI, 8'h55);
    rd = 8'h00;
    for (int n = 0; n < 120 && !rd[IRQ_FLAG_BIT]; n++) bus(1'b0, OFF_IRQ_STAT, 8'h00, 4'h1);
    m_run = 1'b0;
    v = ($time - t0) / 40;
    `CHK(v >= 250 && v <= 275, 1);
    `CHK(irq, 0);
    rdc(OFF_CLKCTRL, 8'h20);
    cnt_rd(1, v);
    `CHK(v >= 22 && v <= 28, 1);
    m_cnt[1] = v;
    repeat (20) @(posedge ref_clk);
    cnt_rd(1, v);
    `CHK(v, m_cnt[1]);
    // interrupt mask and clear
    wr(OFF_IRQ_MASK, 8'h20);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1);
    wr(OFF_IRQ_STAT, 8'h20);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 0);
    // oscillator overflow under both source choices
    run_case(8'h03, 8'h10, 8'h20);
    run_case(8'h02, 8'h30, 8'h00);
    // port c sharing and analog switches
    rnd = $random(seed);
    wr(OFF_PC_DIR, 8'hff);
    wr(OFF_PC_OUT, rnd);
    repeat (2) @(posedge ref_clk);
    `CHK(pc_out, {rnd[7:3], 3'b000});
    `CHK(pc_oe_n, 8'h07);
    wr(OFF_SW_SEL, 8'hff);
    repeat (2) @(posedge ref_clk);
    `CHK(touch_switch_lines, 8'h07);
    rnd = $random(seed);
    pc_in <= rnd;
    repeat (4) @(posedge ref_clk);
    bus(1'b0, OFF_PC_IN, 8'h00, 4'h1);
    `CHK(rd[7:3], rnd[7:3]);
    conclude();
  end
endmodule
